// ===== verification/sttf_monitor.sv
// Concurrent checks on the system timers top: read path, interrupt gating and tick routing.
// Assumes it is bound to sttf_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "sttf_defines.svh"

module sttf_monitor (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [15:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_rd,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic i_t1_overflow,
	input wire logic o_rx_baud_tick,
	input wire logic o_tx_baud_tick,
	input wire logic o_t2_irq,
	input wire logic o_t3_irq,
	input wire logic o_t4_irq,
	input wire logic o_t5_irq
);
	// ------------------------------------------------------------------------
	// Helper decode
	// ------------------------------------------------------------------------
	logic w_mapped;
	logic w_wr_t2;
	logic w_wr_t34;
	logic w_wr_t5;
	logic [1:0] sel_q;
	// The map is sparse, so every register is listed
	assign w_mapped = i_sfr_addr inside {`STTF_ADDR_T4_LOW, `STTF_ADDR_T4_HIGH,
		`STTF_ADDR_T3_LOW, `STTF_ADDR_T3_HIGH, `STTF_ADDR_T2_CTRL, `STTF_ADDR_T2_RLD_LOW,
		`STTF_ADDR_T2_RLD_HIGH, `STTF_ADDR_T2_LOW, `STTF_ADDR_T2_HIGH, `STTF_ADDR_T34_CTRL,
		`STTF_ADDR_T5_CTRL, `STTF_ADDR_T5_LOW, `STTF_ADDR_T5_MID, `STTF_ADDR_T5_TOP};
	assign w_wr_t2 = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T2_CTRL);
	assign w_wr_t34 = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T34_CTRL);
	assign w_wr_t5 = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T5_CTRL);
	// Shadow of the serial selects; hardware never changes them, so a copy is exact
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sel_q <= 2'h0;
		end else if (w_wr_t2) begin
			sel_q <= i_sfr_wdata[5:4];
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	// ------------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------------
	property p_unmapped_zero;
		i_sfr_rd && !w_mapped |=> o_sfr_rdata == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
	property p_rdata_holds;
		!i_sfr_rd |=> $stable(o_sfr_rdata);
	endproperty
	a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
	property p_t5_mask;
		i_sfr_rd && (i_sfr_addr == `STTF_ADDR_T5_CTRL) |=> o_sfr_rdata[2:1] == 2'h0;
	endproperty
	a_t5_mask: assert property (p_t5_mask) else $error("timer 5 spare bits set");
	property p_t2_flag_write;
		w_wr_t2 && i_sfr_wdata[7] |-> ##2 o_t2_irq;
	endproperty
	a_t2_flag_write: assert property (p_t2_flag_write) else $error("t2 flag lost");
	property p_t3_gate;
		w_wr_t34 && !i_sfr_wdata[0] |-> ##2 !o_t3_irq;
	endproperty
	a_t3_gate: assert property (p_t3_gate) else $error("t3 request not blocked");
	property p_t4_gate;
		w_wr_t34 && !i_sfr_wdata[4] |-> ##2 !o_t4_irq;
	endproperty
	a_t4_gate: assert property (p_t4_gate) else $error("t4 request not blocked");
	property p_t5_gate;
		w_wr_t5 && !i_sfr_wdata[0] |-> ##2 !o_t5_irq;
	endproperty
	a_t5_gate: assert property (p_t5_gate) else $error("t5 request not blocked");
	property p_tx_from_t1;
		!sel_q[0] |=> o_tx_baud_tick == $past(i_t1_overflow);
	endproperty
	a_tx_from_t1: assert property (p_tx_from_t1) else $error("tx tick not timer 1");
	property p_rx_from_t1;
		!sel_q[1] |=> o_rx_baud_tick == $past(i_t1_overflow);
	endproperty
	a_rx_from_t1: assert property (p_rx_from_t1) else $error("rx tick not timer 1");

	c_t3_irq: cover property ($rose(o_t3_irq));
	c_rx_t2: cover property (sel_q[1] && o_rx_baud_tick);
	c_t5_irq: cover property ($rose(o_t5_irq));
endmodule

bind sttf_top sttf_monitor sttf_monitor_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
	.i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .i_t1_overflow(i_t1_overflow),
	.o_rx_baud_tick(o_rx_baud_tick), .o_tx_baud_tick(o_tx_baud_tick), .o_t2_irq(o_t2_irq),
	.o_t3_irq(o_t3_irq), .o_t4_irq(o_t4_irq), .o_t5_irq(o_t5_irq));
`default_nettype wire

// ===== verification/sttf_top_tb_top.sv
// Self-checking bench for the system timers top, driving its register path and pins.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sttf_defines.svh"

module sttf_top_tb_top;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [15:0] i_sfr_addr = 16'h0000;
	logic i_sfr_wr = 1'b0;
	logic [7:0] i_sfr_wdata = 8'h00;
	logic i_sfr_rd = 1'b0;
	logic i_t2_count_pin = 1'b1;
	logic i_t1_overflow = 1'b0;
	logic i_internal_fast_osc = 1'b0;
	logic i_slow_osc_32k = 1'b0;
	logic [7:0] o_sfr_rdata;
	logic o_rx_baud_tick, o_tx_baud_tick, o_t2_irq, o_t3_irq, o_t4_irq, o_t5_irq;
	logic [3:0] w_irqs;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] exp_v;
	logic [31:0] rnd;
	int num_errors = 0;
	int comparisons = 0;
	int rx_cnt = 0;
	int tx_cnt = 0;
	int n0;
	int n1;
	logic [15:0] regs [14] = '{`STTF_ADDR_T4_LOW, `STTF_ADDR_T4_HIGH, `STTF_ADDR_T3_LOW,
		`STTF_ADDR_T3_HIGH, `STTF_ADDR_T2_CTRL, `STTF_ADDR_T2_RLD_LOW, `STTF_ADDR_T2_RLD_HIGH,
		`STTF_ADDR_T2_LOW, `STTF_ADDR_T2_HIGH, `STTF_ADDR_T34_CTRL, `STTF_ADDR_T5_CTRL,
		`STTF_ADDR_T5_LOW, `STTF_ADDR_T5_MID, `STTF_ADDR_T5_TOP};

	assign w_irqs = {o_t5_irq, o_t4_irq, o_t3_irq, o_t2_irq};
	// Clocks; the fast oscillator runs free at one fifth of the system rate
	always #20 i_clk = ~i_clk;
	always #100 i_internal_fast_osc = ~i_internal_fast_osc;

	sttf_top sttf_top_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sfr_addr(i_sfr_addr),
		.i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd),
		.o_sfr_rdata(o_sfr_rdata), .i_t2_count_pin(i_t2_count_pin),
		.i_t1_overflow(i_t1_overflow), .i_internal_fast_osc(i_internal_fast_osc),
		.i_slow_osc_32k(i_slow_osc_32k), .o_rx_baud_tick(o_rx_baud_tick),
		.o_tx_baud_tick(o_tx_baud_tick), .o_t2_irq(o_t2_irq), .o_t3_irq(o_t3_irq),
		.o_t4_irq(o_t4_irq), .o_t5_irq(o_t5_irq));

	// ------------------------------------------------------------------------
	// Result watcher: read data lands one edge after the read is taken
	// ------------------------------------------------------------------------
	always @(posedge i_clk) begin
		rd_seen <= i_sfr_rd;
		rx_cnt <= rx_cnt + int'(o_rx_baud_tick === 1'b1);
		tx_cnt <= tx_cnt + int'(o_tx_baud_tick === 1'b1);
	end
	always @(negedge i_clk) begin
		if (rd_seen) begin
			exp_v = exp_q.pop_front();
			comparisons++;
			if (o_sfr_rdata !== exp_v) begin
				num_errors++;
				$display("ERROR t=%0t read %h expected %h", $time, o_sfr_rdata, exp_v);
			end
		end
	end

	// ------------------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------------------
	task automatic conclude();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_sfr_addr <= a;
		i_sfr_wdata <= d;
		i_sfr_wr <= 1'b1;
		@(posedge i_clk);
		i_sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge i_clk);
		i_sfr_addr <= a;
		i_sfr_rd <= 1'b1;
		@(posedge i_clk);
		i_sfr_rd <= 1'b0;
	endtask
	task automatic chk(input logic got, input logic e);
		@(negedge i_clk);
		comparisons++;
		if (got !== e) begin
			num_errors++;
			$display("ERROR t=%0t output %b expected %b", $time, got, e);
		end
	endtask
	// Bounded wait for one interrupt line; running out ends the run
	task automatic wait_irq(input int k);
		int n;
		n = 0;
		while (w_irqs[k] !== 1'b1 && n < 300) begin
			@(negedge i_clk);
			n++;
		end
		comparisons++;
		if (n >= 300) begin
			num_errors++;
			$display("ERROR t=%0t interrupt %0d never rose", $time, k);
			conclude();
		end
	endtask
	task automatic pin_fall();
		@(posedge i_clk);
		i_t2_count_pin <= 1'b0;
		idle(4);
		i_t2_count_pin <= 1'b1;
		idle(4);
	endtask

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		rnd = $urandom(32'h773D98DF);
		idle(2);
		i_rst_b <= 1'b1;
		idle(4);
		// Reset values, unmapped place, random read-back
		foreach (regs[i]) rd(regs[i], `STTF_REG_RESET);
		wr(16'h00C9, 8'h5A);
		rd(16'h00C9, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rnd = $urandom();
			wr(`STTF_ADDR_T2_RLD_LOW, rnd[7:0]);
			wr(`STTF_ADDR_T2_RLD_HIGH, rnd[15:8]);
			rd(`STTF_ADDR_T2_RLD_HIGH, rnd[15:8]);
			rd(`STTF_ADDR_T2_LOW, 8'h00);
		end
		// Timer 3 free-run wrap, flag, gate, then a write held while stopped
		wr(`STTF_ADDR_T3_HIGH, 8'hFF);
		wr(`STTF_ADDR_T3_LOW, 8'hF0);
		wr(`STTF_ADDR_T34_CTRL, 8'h03);
		wait_irq(1);
		rd(`STTF_ADDR_T3_HIGH, 8'h00);
		rd(`STTF_ADDR_T34_CTRL, 8'h0B);
		wr(`STTF_ADDR_T34_CTRL, 8'h08);
		wr(`STTF_ADDR_T3_HIGH, 8'h12);
		wr(`STTF_ADDR_T3_LOW, 8'h34);
		chk(o_t3_irq, 1'b0);
		idle(10);
		rd(`STTF_ADDR_T3_HIGH, 8'h12);
		rd(`STTF_ADDR_T3_LOW, 8'h34);
		// Timer 4: writes in reload mode go to the reload value only
		wr(`STTF_ADDR_T4_HIGH, 8'hFF);
		wr(`STTF_ADDR_T4_LOW, 8'hF0);
		wr(`STTF_ADDR_T34_CTRL, 8'h40);
		wr(`STTF_ADDR_T4_HIGH, 8'hAB);
		wr(`STTF_ADDR_T4_LOW, 8'hCD);
		rd(`STTF_ADDR_T4_LOW, 8'hF0);
		wr(`STTF_ADDR_T34_CTRL, 8'h70);
		wait_irq(2);
		rd(`STTF_ADDR_T4_HIGH, 8'hAB);
		rd(`STTF_ADDR_T34_CTRL, 8'hF0);
		wr(`STTF_ADDR_T34_CTRL, 8'h00);
		// Timer 2 auto-reload, then capture mode which wraps
		wr(`STTF_ADDR_T2_RLD_HIGH, 8'h80);
		wr(`STTF_ADDR_T2_RLD_LOW, 8'h00);
		wr(`STTF_ADDR_T2_HIGH, 8'hFF);
		wr(`STTF_ADDR_T2_LOW, 8'hFF);
		wr(`STTF_ADDR_T2_CTRL, 8'h04);
		wait_irq(0);
		rd(`STTF_ADDR_T2_HIGH, 8'h80);
		rd(`STTF_ADDR_T2_CTRL, 8'h84);
		wr(`STTF_ADDR_T2_CTRL, 8'h00);
		wr(`STTF_ADDR_T2_HIGH, 8'hFF);
		wr(`STTF_ADDR_T2_LOW, 8'hFF);
		wr(`STTF_ADDR_T2_CTRL, 8'h05);
		wait_irq(0);
		rd(`STTF_ADDR_T2_HIGH, 8'h00);
		// Trigger edge: capture into reload, then reload from it
		wr(`STTF_ADDR_T2_CTRL, 8'h00);
		wr(`STTF_ADDR_T2_HIGH, 8'h55);
		wr(`STTF_ADDR_T2_CTRL, 8'h0D);
		pin_fall();
		rd(`STTF_ADDR_T2_RLD_HIGH, 8'h55);
		rd(`STTF_ADDR_T2_CTRL, 8'h4D);
		wr(`STTF_ADDR_T2_RLD_HIGH, 8'h66);
		wr(`STTF_ADDR_T2_CTRL, 8'h0C);
		pin_fall();
		rd(`STTF_ADDR_T2_HIGH, 8'h66);
		// Counter mode on the shared pin
		wr(`STTF_ADDR_T2_CTRL, 8'h00);
		wr(`STTF_ADDR_T2_HIGH, 8'h00);
		wr(`STTF_ADDR_T2_LOW, 8'h00);
		wr(`STTF_ADDR_T2_CTRL, 8'h06);
		repeat (3) pin_fall();
		rd(`STTF_ADDR_T2_LOW, 8'h03);
		// Baud mode with capture select set still reloads and sets no flag
		wr(`STTF_ADDR_T2_CTRL, 8'h80);
		wr(`STTF_ADDR_T2_HIGH, 8'hFF);
		wr(`STTF_ADDR_T2_LOW, 8'hF0);
		wr(`STTF_ADDR_T2_RLD_HIGH, 8'hFF);
		wr(`STTF_ADDR_T2_RLD_LOW, 8'hF0);
		n0 = rx_cnt;
		n1 = tx_cnt;
		wr(`STTF_ADDR_T2_CTRL, 8'h35);
		idle(100);
		rd(`STTF_ADDR_T2_CTRL, 8'h35);
		chk(rx_cnt - n0 >= 2, 1'b1);
		chk(tx_cnt - n1 >= 2, 1'b1);
		wr(`STTF_ADDR_T2_CTRL, 8'h00);
		@(posedge i_clk);
		i_t1_overflow <= 1'b1;
		@(posedge i_clk);
		i_t1_overflow <= 1'b0;
		n1 = tx_cnt;
		idle(3);
		chk(tx_cnt - n1 == 1, 1'b1);
		// Timer 5 on each clock select code
		wr(`STTF_ADDR_T5_CTRL, 8'h06);
		rd(`STTF_ADDR_T5_CTRL, 8'h00);
		for (int s = 0; s < 2; s++) begin
			wr(`STTF_ADDR_T5_TOP, 8'hFF);
			wr(`STTF_ADDR_T5_MID, 8'hFF);
			wr(`STTF_ADDR_T5_LOW, 8'hFE);
			wr(`STTF_ADDR_T5_CTRL, s ? 8'h29 : 8'h09);
			wait_irq(3);
			rd(`STTF_ADDR_T5_TOP, 8'h00);
			rd(`STTF_ADDR_T5_CTRL, s ? 8'hA9 : 8'h89);
			wr(`STTF_ADDR_T5_CTRL, 8'h00);
		end
		for (int s = 0; s < 2; s++) begin
			wr(`STTF_ADDR_T5_CTRL, s ? 8'h60 : 8'h40);
			wr(`STTF_ADDR_T5_LOW, 8'h11);
			wr(`STTF_ADDR_T5_CTRL, s ? 8'h68 : 8'h48);
			idle(40);
			rd(`STTF_ADDR_T5_LOW, 8'h11);
		end
		idle(4);
		conclude();
	end
endmodule
`default_nettype wire

// ===== verilog/sttf_defines.svh
// Register offsets, field positions, reset values and prescale counts for the
// system timers block. Assumes a 16-bit special-function/external address space.
`ifndef STTF_DEFINES_SVH
`define STTF_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define STTF_ADDR_T4_LOW 16'h00AC
`define STTF_ADDR_T4_HIGH 16'h00AD
`define STTF_ADDR_T3_LOW 16'h00AE
`define STTF_ADDR_T3_HIGH 16'h00AF
`define STTF_ADDR_T2_CTRL 16'h00C8
`define STTF_ADDR_T2_RLD_LOW 16'h00CA
`define STTF_ADDR_T2_RLD_HIGH 16'h00CB
`define STTF_ADDR_T2_LOW 16'h00CC
`define STTF_ADDR_T2_HIGH 16'h00CD
`define STTF_ADDR_T34_CTRL 16'h00CF
`define STTF_ADDR_T5_CTRL 16'hA068
`define STTF_ADDR_T5_LOW 16'hA069
`define STTF_ADDR_T5_MID 16'hA06A
`define STTF_ADDR_T5_TOP 16'hA06B

// ----------------------------------------------------------------------------
// Timer 2 control fields
// ----------------------------------------------------------------------------
`define STTF_T2_FLAG 7
`define STTF_T2_EXT_FLAG 6
`define STTF_T2_RX_SEL 5
`define STTF_T2_TX_SEL 4
`define STTF_T2_TRIG_EN 3
`define STTF_T2_RUN 2
`define STTF_T2_CNT_SEL 1
`define STTF_T2_CAP_SEL 0

// ----------------------------------------------------------------------------
// Timer 3/4 nibble fields (timer 4 in bits 7:4, timer 3 in bits 3:0)
// ----------------------------------------------------------------------------
`define STTF_T34_FLAG 3
`define STTF_T34_MODE 2
`define STTF_T34_RUN 1
`define STTF_T34_IEN 0

// ----------------------------------------------------------------------------
// Timer 5 control fields
// ----------------------------------------------------------------------------
`define STTF_T5_FLAG 7
`define STTF_T5_SEL_HI 6
`define STTF_T5_MODE 4
`define STTF_T5_RUN 3
`define STTF_T5_IEN 0
`define STTF_T5_CTRL_MASK 8'hF9

// ----------------------------------------------------------------------------
// Reset values and prescale counts
// ----------------------------------------------------------------------------
`define STTF_REG_RESET 8'h00
`define STTF_T2_DIV_TIMER 4'hC
`define STTF_T2_DIV_BAUD 4'h2

`endif

// ===== verilog/sttf_pkg.sv
// Types shared by the system timers block.
// Assumes nothing beyond a SystemVerilog compiler.
package sttf_pkg;
	typedef enum logic [1:0] {
		T2_STOPPED,
		T2_AUTO_RELOAD,
		T2_CAPTURE,
		T2_BAUD_GEN
	} sttf_t2_mode_type;
endpackage

// ===== verilog/sttf_top.sv
// System timers 2 to 5 behind the CPU special-function-register path.
// Assumes a single system clock; oscillator and pin inputs are asynchronous.
//
// Summary of operation
// R1: Timer-2 flag not set in baud mode
// R2: Serial directions take timer 2 or timer 1
// R3: Capture select picks capture or reload trigger
// R4: Baud mode always reloads on overflow
// R5: Mode decoded from selects; run clear stops
// R6: Auto-reload overflow sets flag, reloads count
// R7: Capture overflow sets flag; trigger copies count
// R8: Baud mode overflow drives serial bit clock
// R9: Count pin and trigger pin are shared
// R10: Timer mode prescales by twelve or two
// R11: Counter mode counts sampled pin falling edges
// R12: Timers 3 and 4 count system clocks
// R13: Hardware sets overflow flags; software clears
// R14: Mode bit picks reload or free-run
// R15: Timers count only while run set
// R16: Interrupt request gated by enable bit; the timer 2 request has no enable and is not gated
// R17: Count writes hit reload or counter
// R18: Count reads return live counter value
// R19: Software reads high byte then low
// R20: Timer 5 is a 24-bit counter
// R21: Clock select picks fast or slow oscillator
// R22: Timer 5 counts on oscillator, ignoring sleep
// R23: Reload after all-ones, else wrap to zero
// R24: Timer 5 clock crossed safely into system clock
`timescale 1ns/1ps
`default_nettype none
`include "sttf_defines.svh"

module sttf_top
	import sttf_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [15:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_rd,
	output logic [7:0] o_sfr_rdata,
	input wire logic i_t2_count_pin,
	input wire logic i_t1_overflow,
	input wire logic i_internal_fast_osc,
	input wire logic i_slow_osc_32k,
	output logic o_rx_baud_tick,
	output logic o_tx_baud_tick,
	output logic o_t2_irq,
	output logic o_t3_irq,
	output logic o_t4_irq,
	output logic o_t5_irq
);

	// ------------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------------
	logic rst_meta;
	logic rst_b;
	// Deassertion synchronised so all timers leave reset on the same edge
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_b <= rst_meta;
		end
	end

	// ------------------------------------------------------------------------
	// Byte replacement helper
	// ------------------------------------------------------------------------
	function automatic logic [23:0] put_byte(input logic [23:0] value, input logic [1:0] idx,
		input logic [7:0] data);
		logic [23:0] result;
		result = value;
		case (idx)
			2'h0: result[7:0] = data;
			2'h1: result[15:8] = data;
			default: result[23:16] = data;
		endcase
		return result;
	endfunction

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	logic pin_meta, pin_sync, pin_prev;
	logic fast_meta, fast_sync, slow_meta, slow_sync;
	logic t5_src, t5_src_prev;
	// Two flops per asynchronous input, then one more for edge detection
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
			pin_prev <= 1'b1;
			fast_meta <= 1'b0;
			fast_sync <= 1'b0;
			slow_meta <= 1'b0;
			slow_sync <= 1'b0;
			t5_src_prev <= 1'b0;
		end else begin
			pin_meta <= i_t2_count_pin; // [R9]
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
			fast_meta <= i_internal_fast_osc;
			fast_sync <= fast_meta;
			slow_meta <= i_slow_osc_32k;
			slow_sync <= slow_meta;
			t5_src_prev <= t5_src; // [R24]
		end
	end

	// ------------------------------------------------------------------------
	// Register strobes
	// ------------------------------------------------------------------------
	wire wr_t2_ctrl = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T2_CTRL);
	wire wr_t2_rld_lo = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T2_RLD_LOW);
	wire wr_t2_rld_hi = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T2_RLD_HIGH);
	wire wr_t2_lo = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T2_LOW);
	wire wr_t2_hi = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T2_HIGH);
	wire wr_t34_ctrl = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T34_CTRL);
	wire wr_t5_ctrl = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T5_CTRL);
	wire wr_t5_lo = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T5_LOW);
	wire wr_t5_mid = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T5_MID);
	wire wr_t5_top = i_sfr_wr && (i_sfr_addr == `STTF_ADDR_T5_TOP);

	// ------------------------------------------------------------------------
	// Timer 2
	// ------------------------------------------------------------------------
	logic [7:0] t2_control;
	logic [15:0] t2_count;
	logic [15:0] t2_reload;
	logic [3:0] t2_prescale;
	sttf_t2_mode_type t2_mode;

	wire t2_baud_sel = t2_control[`STTF_T2_RX_SEL] | t2_control[`STTF_T2_TX_SEL];
	// Run clear overrides every other select
	assign t2_mode = !t2_control[`STTF_T2_RUN] ? T2_STOPPED : // [R5]
		t2_baud_sel ? T2_BAUD_GEN : // [R5]
		t2_control[`STTF_T2_CAP_SEL] ? T2_CAPTURE : T2_AUTO_RELOAD;
	// Prescale terminal: twelve clocks normally, two when generating baud
	wire [3:0] t2_div = (t2_mode == T2_BAUD_GEN) ? `STTF_T2_DIV_BAUD : `STTF_T2_DIV_TIMER;
	wire t2_pre_hit = (t2_prescale == (t2_div - 4'h1)); // [R10]
	wire pin_fall = pin_prev & ~pin_sync; // [R11]
	wire t2_running = (t2_mode != T2_STOPPED);
	wire t2_tick = t2_running && (t2_control[`STTF_T2_CNT_SEL] ? pin_fall : t2_pre_hit);
	wire t2_ovf = t2_tick && (t2_count == 16'hFFFF);
	wire t2_trigger = t2_running && pin_fall && t2_control[`STTF_T2_TRIG_EN]; // [R9]
	wire t2_reloading = (t2_mode != T2_CAPTURE); // [R4]
	wire t2_capture = t2_trigger && (t2_mode == T2_CAPTURE); // [R3] [R7]
	wire t2_trig_reload = t2_trigger && (t2_mode == T2_AUTO_RELOAD); // [R3]
	wire t2_flag_set = t2_ovf && !t2_baud_sel; // [R1]
	// Prescaler restarts whenever the timer is stopped
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			t2_prescale <= 4'h0;
		end else if (!t2_running || t2_pre_hit) begin
			t2_prescale <= 4'h0;
		end else begin
			t2_prescale <= t2_prescale + 4'h1; // [R10]
		end
	end
	// Software write beats hardware update in the same cycle
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			t2_count <= {2{`STTF_REG_RESET}};
		end else if (wr_t2_lo) begin
			t2_count[7:0] <= i_sfr_wdata;
		end else if (wr_t2_hi) begin
			t2_count[15:8] <= i_sfr_wdata;
		end else if ((t2_ovf && t2_reloading) || t2_trig_reload) begin
			t2_count <= t2_reload; // [R3] [R4] [R6]
		end else if (t2_tick) begin
			t2_count <= t2_count + 16'h0001; // [R7]
		end
	end
	// Capture copies the live count into the reload pair
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			t2_reload <= {2{`STTF_REG_RESET}};
		end else if (t2_capture) begin
			t2_reload <= t2_count; // [R7]
		end else if (wr_t2_rld_lo) begin
			t2_reload[7:0] <= i_sfr_wdata;
		end else if (wr_t2_rld_hi) begin
			t2_reload[15:8] <= i_sfr_wdata;
		end
	end
	// Flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			t2_control <= `STTF_REG_RESET;
		end else begin
			if (wr_t2_ctrl) begin
				t2_control <= i_sfr_wdata;
			end
			if (t2_flag_set) begin
				t2_control[`STTF_T2_FLAG] <= 1'b1; // [R1] [R6] [R7]
			end
			if (t2_trigger) begin
				t2_control[`STTF_T2_EXT_FLAG] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Timers 3 and 4 (index 0 is timer 3, index 1 is timer 4)
	// ------------------------------------------------------------------------
	logic [3:0] ctl34 [0:1];
	logic [15:0] cnt34 [0:1];
	logic [15:0] rld34 [0:1];
	logic [1:0] irq34;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_t34
			wire [15:0] addr_lo = (gi == 0) ? `STTF_ADDR_T3_LOW : `STTF_ADDR_T4_LOW;
			wire [15:0] addr_hi = (gi == 0) ? `STTF_ADDR_T3_HIGH : `STTF_ADDR_T4_HIGH;
			wire wr_lo = i_sfr_wr && (i_sfr_addr == addr_lo);
			wire wr_hi = i_sfr_wr && (i_sfr_addr == addr_hi);
			wire wr_any = wr_lo | wr_hi;
			wire [1:0] byte_idx = wr_hi ? 2'h1 : 2'h0;
			wire reload_mode = ctl34[gi][`STTF_T34_MODE]; // [R14]
			wire tick = ctl34[gi][`STTF_T34_RUN]; // [R12] [R15]
			wire ovf = tick && (cnt34[gi] == 16'hFFFF);
			wire [23:0] cnt_wr = put_byte({8'h00, cnt34[gi]}, byte_idx, i_sfr_wdata);
			wire [23:0] rld_wr = put_byte({8'h00, rld34[gi]}, byte_idx, i_sfr_wdata);
			wire [7:0] wr_ctl = i_sfr_wdata >> (4 * gi);
			// Counter: write in free-run, reload or wrap on overflow, else count
			always_ff @(posedge i_clk or negedge rst_b) begin
				if (!rst_b) begin
					cnt34[gi] <= {2{`STTF_REG_RESET}};
				end else if (wr_any && !reload_mode) begin
					cnt34[gi] <= cnt_wr[15:0]; // [R17]
				end else if (ovf) begin
					cnt34[gi] <= reload_mode ? rld34[gi] : 16'h0000; // [R23]
				end else if (tick) begin
					cnt34[gi] <= cnt34[gi] + 16'h0001; // [R12]
				end
			end
			// Reload value only takes writes in reload mode
			always_ff @(posedge i_clk or negedge rst_b) begin
				if (!rst_b) begin
					rld34[gi] <= {2{`STTF_REG_RESET}};
				end else if (wr_any && reload_mode) begin
					rld34[gi] <= rld_wr[15:0]; // [R17]
				end
			end
			// Control nibble with sticky overflow flag
			always_ff @(posedge i_clk or negedge rst_b) begin
				if (!rst_b) begin
					ctl34[gi] <= 4'h0;
				end else begin
					if (wr_t34_ctrl) begin
						ctl34[gi] <= wr_ctl[3:0];
					end
					if (ovf) begin
						ctl34[gi][`STTF_T34_FLAG] <= 1'b1; // [R13]
					end
				end
			end

			assign irq34[gi] = ctl34[gi][`STTF_T34_FLAG] & ctl34[gi][`STTF_T34_IEN]; // [R16]
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Timer 5
	// ------------------------------------------------------------------------
	logic [7:0] t5_control;
	logic [23:0] t5_count;
	logic [23:0] t5_reload;
	// Oscillators are sampled, so each must run below half the system clock
	assign t5_src = t5_control[`STTF_T5_SEL_HI] ? slow_sync : fast_sync; // [R21]
	wire t5_edge = t5_src & ~t5_src_prev; // [R24]
	wire t5_tick = t5_control[`STTF_T5_RUN] && t5_edge; // [R15] [R22]
	wire t5_ovf = t5_tick && (t5_count == 24'hFFFFFF);
	wire t5_reload_mode = t5_control[`STTF_T5_MODE]; // [R14]
	wire t5_wr_any = wr_t5_lo | wr_t5_mid | wr_t5_top;
	wire [1:0] t5_idx = wr_t5_top ? 2'h2 : (wr_t5_mid ? 2'h1 : 2'h0);
	// 24-bit counter; no sleep input gates it
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			t5_count <= {3{`STTF_REG_RESET}};
		end else if (t5_wr_any && !t5_reload_mode) begin
			t5_count <= put_byte(t5_count, t5_idx, i_sfr_wdata); // [R17]
		end else if (t5_ovf) begin
			t5_count <= t5_reload_mode ? t5_reload : 24'h000000; // [R23]
		end else if (t5_tick) begin
			t5_count <= t5_count + 24'h000001; // [R20] [R22]
		end
	end
	// Reload value written only in reload mode
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			t5_reload <= {3{`STTF_REG_RESET}};
		end else if (t5_wr_any && t5_reload_mode) begin
			t5_reload <= put_byte(t5_reload, t5_idx, i_sfr_wdata); // [R17]
		end
	end
	// Control with sticky flag; bits 2:1 forced to zero, unused bit 5 kept as written
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			t5_control <= `STTF_REG_RESET;
		end else begin
			if (wr_t5_ctrl) begin
				t5_control <= i_sfr_wdata & `STTF_T5_CTRL_MASK;
			end
			if (t5_ovf) begin
				t5_control[`STTF_T5_FLAG] <= 1'b1; // [R13]
			end
		end
	end

	// ------------------------------------------------------------------------
	// Read path and outputs
	// ------------------------------------------------------------------------
	logic [7:0] next_rdata;
	// Live counter bytes, no snapshot; unmapped addresses read zero
	always_comb begin
		case (i_sfr_addr)
			`STTF_ADDR_T2_CTRL: next_rdata = t2_control;
			`STTF_ADDR_T2_RLD_LOW: next_rdata = t2_reload[7:0];
			`STTF_ADDR_T2_RLD_HIGH: next_rdata = t2_reload[15:8];
			`STTF_ADDR_T2_LOW: next_rdata = t2_count[7:0];
			`STTF_ADDR_T2_HIGH: next_rdata = t2_count[15:8];
			`STTF_ADDR_T34_CTRL: next_rdata = {ctl34[1], ctl34[0]};
			`STTF_ADDR_T3_LOW: next_rdata = cnt34[0][7:0]; // [R18]
			`STTF_ADDR_T3_HIGH: next_rdata = cnt34[0][15:8]; // [R18]
			`STTF_ADDR_T4_LOW: next_rdata = cnt34[1][7:0];
			`STTF_ADDR_T4_HIGH: next_rdata = cnt34[1][15:8];
			`STTF_ADDR_T5_CTRL: next_rdata = t5_control;
			`STTF_ADDR_T5_LOW: next_rdata = t5_count[7:0]; // [R18]
			`STTF_ADDR_T5_MID: next_rdata = t5_count[15:8];
			`STTF_ADDR_T5_TOP: next_rdata = t5_count[23:16];
			default: next_rdata = 8'h00;
		endcase
	end
	// All outputs registered; read data holds until the next read
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_sfr_rdata <= 8'h00;
			o_rx_baud_tick <= 1'b0;
			o_tx_baud_tick <= 1'b0;
			o_t2_irq <= 1'b0;
			o_t3_irq <= 1'b0;
			o_t4_irq <= 1'b0;
			o_t5_irq <= 1'b0;
		end else begin
			if (i_sfr_rd) begin
				o_sfr_rdata <= next_rdata;
			end
			o_rx_baud_tick <= t2_control[`STTF_T2_RX_SEL] ? t2_ovf : i_t1_overflow; // [R2] [R8]
			o_tx_baud_tick <= t2_control[`STTF_T2_TX_SEL] ? t2_ovf : i_t1_overflow; // [R2] [R8]
			o_t2_irq <= t2_control[`STTF_T2_FLAG] | t2_control[`STTF_T2_EXT_FLAG];
			o_t3_irq <= irq34[0];
			o_t4_irq <= irq34[1];
			o_t5_irq <= t5_control[`STTF_T5_FLAG] & t5_control[`STTF_T5_IEN]; // [R16]
		end
	end

endmodule
`default_nettype wire
